// [hdl/spi_board_select_fabric.sv]
// SPI master with slave select fabric and radio sideband lines
`include "spi_fabric_defines.svh"

module spi_board_select_fabric
   import spi_fabric_pkg::*;
#(
   parameter int HALF_CYCLES = `SCLK_HALF_CYC,
   parameter int FIFO_DEPTH = `CMD_FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   // Command side
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire cmd_type cmd,
   // Receive side
   output logic rx_valid,
   input wire logic rx_ready,
   output rx_type rx,
   output logic busy,
   // Radio control from the user side
   input wire logic radio_reset_req,
   input wire logic radio_power_on,
   output radio_status_type radio_status,
   // Serial pins
   output logic sclk,
   output logic mosi,
   input wire logic miso,
   output logic power_ctrl_select_n,
   output logic radio_select_n,
   output logic board_select_near_n,
   output logic board_select_far_n,
   output logic sub_addr_bit0,
   output logic sub_addr_bit1,
   output logic sub_addr_bit2,
   // Radio sideband pins
   output logic radio_reset_n,
   output logic radio_regulator_enable,
   input wire logic rx_threshold_flag,
   input wire logic rx_bytes_present,
   input wire logic frame_start,
   input wire logic channel_clear
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************

   // The half period timer is eight bits wide
   if (HALF_CYCLES < 1 || HALF_CYCLES > 256) begin : g_bad_half
      $error("HALF_CYCLES must lie between 1 and 256");
   end

   localparam logic [7:0] HALF_RELOAD = 8'(HALF_CYCLES - 1);

   // ****************************************************************
   // Declarations
   // ****************************************************************

   state_type state;
   logic [7:0] tmr;
   logic [3:0] edge_cnt;
   cmd_type cur;
   logic [7:0] tx_sh;
   logic [7:0] rx_sh;
   logic [3:0] sel_n;
   logic [2:0] sub_addr;
   logic [`SYNC_WIDTH-1:0] sync_raw;
   logic [`SYNC_WIDTH-1:0] sync_1;
   logic [`SYNC_WIDTH-1:0] sync_2;
   logic miso_s;
   logic fifo_valid;
   cmd_type fifo_data;
   logic tick;
   logic pop;
   logic pop_idle;
   logic pop_chain;
   logic chain_match;
   logic chain_break;
   logic edge_now;
   logic leading;
   logic sample_edge;
   logic shift_edge;
   logic assert_now;
   logic byte_done;
   logic release_now;

   // ****************************************************************
   // Command queue
   // ****************************************************************

   // Commands queue here; the sequencer only drains while the receive
   // slot is free, so a slow reader stalls the link and then fills it
   cmd_fifo #(
      .WIDTH($bits(cmd_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_cmd_fifo (
      .clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data(cmd),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_data)
   );

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************

   assign sync_raw = {miso, channel_clear, frame_start, rx_bytes_present, rx_threshold_flag};

   // Two flops per pin; nothing but the second stage reads the first
   for (genvar i = 0; i < `SYNC_WIDTH; i++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            sync_1[i] <= 1'b0;
            sync_2[i] <= 1'b0;
         end else begin
            sync_1[i] <= sync_raw[i];
            sync_2[i] <= sync_1[i];
         end
      end
   end

   // Radio status goes straight out of the second stage
   assign radio_status.threshold = sync_2[0];
   assign radio_status.bytes_present = sync_2[1];
   assign radio_status.frame_start = sync_2[2];
   assign radio_status.channel_clear = sync_2[3];
   assign miso_s = sync_2[4];

   // ****************************************************************
   // Sequencer control terms
   // ****************************************************************

   // Timer expiry marks the end of each half clock period
   assign tick = (tmr == 8'h00);

   // A chained byte must keep target, sub address and mode, or the
   // held select would reach the wrong slave
   assign chain_match = (fifo_data.target == cur.target) && (fifo_data.sub_addr == cur.sub_addr) &&
                        (fifo_data.mode == cur.mode);
   assign pop_idle = (state == ST_IDLE) && fifo_valid && !rx_valid;
   assign pop_chain = (state == ST_CHAIN) && fifo_valid && !rx_valid && chain_match;
   assign chain_break = (state == ST_CHAIN) && fifo_valid && !chain_match;
   assign pop = pop_idle || pop_chain;

   // Clock edges: even count is the leading edge, odd the trailing one
   assign edge_now = (state == ST_SHIFT) && tick;
   assign leading = ~edge_cnt[0];
   assign sample_edge = edge_now && (leading ^ cur.mode.cpha);
   assign shift_edge = edge_now && !(leading ^ cur.mode.cpha);

   // Select changes
   assign assert_now = (state == ST_SETUP) && tick;
   assign byte_done = (state == ST_TAIL) && tick;
   assign release_now = (byte_done && !cur.keep) || chain_break;

   assign busy = (state != ST_IDLE) || fifo_valid;

   // ****************************************************************
   // Sequencer
   // ****************************************************************

   // State, half period timer and edge counter
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         tmr <= 8'h00;
         edge_cnt <= 4'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (pop_idle) begin
                  state <= ST_SETUP;
                  tmr <= HALF_RELOAD;
               end
            end
            ST_SETUP: begin
               // Sub address and clock idle level settle for a half period
               if (tick) begin
                  state <= ST_LEAD;
                  tmr <= HALF_RELOAD;
               end else begin
                  tmr <= tmr - 8'h01;
               end
            end
            ST_LEAD: begin
               // Select is low this half period plus the first shift half period, a full period, before the first edge
               if (tick) begin
                  state <= ST_SHIFT;
                  tmr <= HALF_RELOAD;
                  edge_cnt <= 4'h0;
               end else begin
                  tmr <= tmr - 8'h01;
               end
            end
            ST_SHIFT: begin
               if (tick) begin
                  tmr <= HALF_RELOAD;
                  edge_cnt <= edge_cnt + 4'h1;
                  if (edge_cnt == `LAST_EDGE) begin
                     state <= ST_TAIL;
                  end
               end else begin
                  tmr <= tmr - 8'h01;
               end
            end
            ST_TAIL: begin
               // Hold the select a half period past the last edge
               if (tick) begin
                  tmr <= HALF_RELOAD;
                  if (cur.keep) begin
                     state <= ST_CHAIN;
                  end else begin
                     state <= ST_GAP;
                  end
               end else begin
                  tmr <= tmr - 8'h01;
               end
            end
            ST_CHAIN: begin
               // Select stays low while waiting for the next byte
               if (pop_chain) begin
                  state <= ST_LEAD;
                  tmr <= HALF_RELOAD;
               end else if (chain_break) begin
                  state <= ST_GAP;
                  tmr <= HALF_RELOAD;
               end
            end
            ST_GAP: begin
               // Sub address is held a half period past the release
               if (tick) begin
                  state <= ST_IDLE;
               end else begin
                  tmr <= tmr - 8'h01;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Current command, taken when a byte leaves the queue
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else if (pop) begin
         cur <= fifo_data;
      end
   end

   // ****************************************************************
   // Serial clock and data
   // ****************************************************************

   // Only this block ever drives the clock; it idles at the mode level
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk <= 1'b0;
      end else if (pop_idle) begin
         sclk <= fifo_data.mode.cpol;
      end else if (edge_now) begin
         sclk <= ~sclk;
      end
   end

   // Transmit path: first phase puts bit 7 out before the first edge,
   // second phase puts it out on the leading edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mosi <= 1'b0;
         tx_sh <= 8'h00;
      end else if (pop) begin
         if (!fifo_data.mode.cpha) begin
            mosi <= fifo_data.data[7];
            tx_sh <= {fifo_data.data[6:0], 1'b0};
         end else begin
            tx_sh <= fifo_data.data;
         end
      end else if (shift_edge) begin
         mosi <= tx_sh[7];
         tx_sh <= {tx_sh[6:0], 1'b0};
      end
   end

   // Receive path runs alongside the transmit path, first bit to the top
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sh <= 8'h00;
      end else if (sample_edge) begin
         rx_sh <= {rx_sh[6:0], miso_s};
      end
   end

   // Received byte holds until taken; the set wins over the take
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_valid <= 1'b0;
         rx <= '0;
      end else if (byte_done) begin
         rx_valid <= 1'b1;
         rx.data <= rx_sh;
         rx.target <= cur.target;
      end else if (rx_ready) begin
         rx_valid <= 1'b0;
      end
   end

   // ****************************************************************
   // Slave selects and sub address
   // ****************************************************************

   // Exactly one select goes low per transfer, decoded from the target;
   // the others stay high so only one slave may drive its output line
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_n <= `SELECT_IDLE_N;
      end else if (assert_now) begin
         sel_n <= `SELECT_IDLE_N;
         case (cur.target)
            TGT_POWER: sel_n[`SEL_POWER_BIT] <= 1'b0;
            TGT_RADIO: sel_n[`SEL_RADIO_BIT] <= 1'b0;
            TGT_BOARD_NEAR: sel_n[`SEL_NEAR_BIT] <= 1'b0;
            TGT_BOARD_FAR: sel_n[`SEL_FAR_BIT] <= 1'b0;
            default: sel_n <= `SELECT_IDLE_N;
         endcase
      end else if (release_now) begin
         sel_n <= `SELECT_IDLE_N;
      end
   end

   assign power_ctrl_select_n = sel_n[`SEL_POWER_BIT];
   assign radio_select_n = sel_n[`SEL_RADIO_BIT];
   assign board_select_near_n = sel_n[`SEL_NEAR_BIT];
   assign board_select_far_n = sel_n[`SEL_FAR_BIT];

   // Sub address changes only when starting from idle, with every select
   // high; a chained byte keeps it, so it is stable across the select
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sub_addr <= `SUB_ADDR_RST;
      end else if (pop_idle) begin
         sub_addr <= fifo_data.sub_addr;
      end
   end

   assign sub_addr_bit0 = sub_addr[0];
   assign sub_addr_bit1 = sub_addr[1];
   assign sub_addr_bit2 = sub_addr[2];

   // ****************************************************************
   // Radio sideband outputs
   // ****************************************************************

   // Reset pulls low while requested; regulator follows its request.
   // Both are held in reset state until the first clock after release.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         radio_reset_n <= 1'b0;
         radio_regulator_enable <= 1'b0;
      end else begin
         radio_reset_n <= ~radio_reset_req;
         radio_regulator_enable <= radio_power_on;
      end
   end

endmodule : spi_board_select_fabric

// [hdl/spi_fabric_defines.svh]
// Constants for the SPI master and board select fabric
//
// Notes on behaviour
// - The main processor is always master and alone drives the serial clock.
// - Every slave select is active low, one distinct select per slave device; the devices on a board share its select, told apart by sub address.
// - Bytes travel most significant bit first on both data lines.
// - Data timing follows rising or falling clock edge, chosen per slave.
// - Shifting out on master output also shifts slave output into a receive register.
// - Select asserts before the first clock edge, releases after the byte completes.
// - Separate selects for power controller, radio, and two boards with three-bit sub address.
// - Sub address bit0 is least significant, bit2 most significant.
// - Sub address is stable before a board select asserts and until after release.
// - Near board select addresses the nearest board; a lone board uses it.
// - Radio reset output is active low; high lets the transceiver run.
// - Drive the radio regulator enable; sample four radio status inputs.
`ifndef SPI_FABRIC_DEFINES_SVH
`define SPI_FABRIC_DEFINES_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define REF_CLK_PERIOD_NS 40
`define SCLK_HALF_NS 160
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define LAST_EDGE 4'hF

// ****************************************************************
// Sizes, positions and reset values
// ****************************************************************
`define CMD_FIFO_DEPTH 16
`define SELECT_IDLE_N 4'hF
`define SEL_POWER_BIT 0
`define SEL_RADIO_BIT 1
`define SEL_NEAR_BIT 2
`define SEL_FAR_BIT 3
`define SUB_ADDR_RST 3'h0
`define SUB_ADDR_ID_MEM 3'h7
`define SYNC_WIDTH 5

`endif

// [hdl/spi_fabric_pkg.sv]
// Types shared by the SPI master and board select fabric
package spi_fabric_pkg;

   // Which slave a byte goes to
   typedef enum logic [1:0] {
      TGT_POWER = 2'h0,
      TGT_RADIO = 2'h1,
      TGT_BOARD_NEAR = 2'h2,
      TGT_BOARD_FAR = 2'h3
   } target_type;

   // Clock idle level and sampling phase
   typedef struct packed {
      logic cpol;
      logic cpha;
   } spi_mode_type;

   // One queued byte transfer
   typedef struct packed {
      target_type target;
      logic [2:0] sub_addr;
      spi_mode_type mode;
      logic keep;
      logic [7:0] data;
   } cmd_type;

   // One received byte with the slave it came from
   typedef struct packed {
      target_type target;
      logic [7:0] data;
   } rx_type;

   // Synchronised radio status lines
   typedef struct packed {
      logic channel_clear;
      logic frame_start;
      logic bytes_present;
      logic threshold;
   } radio_status_type;

   // Transfer sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_LEAD = 3'b010,
      ST_SHIFT = 3'b011,
      ST_TAIL = 3'b100,
      ST_CHAIN = 3'b101,
      ST_GAP = 3'b110
   } state_type;

endpackage : spi_fabric_pkg

// [hdl/cmd_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides
module cmd_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointer wrap needs a power of two depth
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("cmd_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic full;
   logic empty;

   // Extra pointer bit tells full from empty
   assign empty = (wr_ptr == rd_ptr);
   assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Write side
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
      end else if (in_valid && !full) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   // Storage has no reset; only written entries are ever read
   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // Read side
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ptr <= '0;
      end else if (out_ready && !empty) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end

endmodule : cmd_fifo

// [sim/spi_fabric_asserts.sv]
// Port-level checker bound into the select fabric
module spi_fabric_asserts
   import spi_fabric_pkg::*;
#(
   parameter int HALF_CYCLES = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic power_ctrl_select_n,
   input wire logic radio_select_n,
   input wire logic board_select_near_n,
   input wire logic board_select_far_n,
   input wire logic sub_addr_bit0,
   input wire logic sub_addr_bit1,
   input wire logic sub_addr_bit2,
   input wire logic rx_valid,
   input wire logic radio_reset_req,
   input wire logic radio_power_on,
   input wire logic radio_reset_n,
   input wire logic radio_regulator_enable,
   input wire logic rx_threshold_flag,
   input wire logic rx_bytes_present,
   input wire logic frame_start,
   input wire logic channel_clear,
   input wire radio_status_type radio_status
);
   logic [3:0] sels;
   logic [2:0] addr;
   logic [3:0] pins;
   logic last_sclk;
   int gap;
   int age;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // Flat views of the pins
   assign sels = {board_select_far_n, board_select_near_n, radio_select_n, power_ctrl_select_n};
   assign addr = {sub_addr_bit2, sub_addr_bit1, sub_addr_bit0};
   assign pins = {channel_clear, frame_start, rx_bytes_present, rx_threshold_flag};

   // ****************************************************************
   // Helper counters
   // ****************************************************************
   // Cycles since a clock edge and since a select fell
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         last_sclk <= 1'h0;
         gap <= 0;
         age <= 0;
      end else begin
         last_sclk <= sclk;
         gap <= (sclk != last_sclk) ? 0 : gap + 1;
         age <= (&sels) ? 0 : age + 1;
      end
   end

   // ****************************************************************
   // Properties
   // ****************************************************************
   a_one_select: assert property ($countones(~sels) <= 1)
      else $error("more than one select low");
   a_addr_stable: assert property (!(board_select_near_n && board_select_far_n) |-> $stable(addr))
      else $error("sub address moved under a board select");
   a_addr_hold: assert property (($rose(board_select_near_n) || $rose(board_select_far_n)) |=> $stable(addr))
      else $error("sub address moved right after release");
   a_sclk_spacing: assert property ((sclk != last_sclk) && !(&sels) |-> gap >= HALF_CYCLES - 1)
      else $error("serial clock edges too close");
   a_select_lead: assert property ((sclk != last_sclk) && !(&sels) |-> age > HALF_CYCLES)
      else $error("clock edge too soon after select");
   a_rx_release: assert property ($rose(rx_valid) |-> $rose(&sels) || !(&sels))
      else $error("byte reported while select idle");
   a_radio_reset: assert property (1'h1 |=> radio_reset_n == !$past(radio_reset_req))
      else $error("radio reset pin wrong");
   a_regulator_follow: assert property (1'h1 |=> radio_regulator_enable == $past(radio_power_on))
      else $error("regulator pin wrong");
   a_status_sync: assert property ($past(rst_n, 2) |-> radio_status == $past(pins, 2))
      else $error("radio status not two cycles behind pins");
endmodule : spi_fabric_asserts

bind spi_board_select_fabric spi_fabric_asserts #(.HALF_CYCLES(HALF_CYCLES)) chk (.*);

// [sim/spi_slave_model.sv]
// SPI slave model for every device on the shared lines
module spi_slave_model (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic sel_n,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] out;

   initial begin
      miso = 1'h0;
      rx_byte = 8'h00;
      out = 8'h00;
   end

   // Load reply; cpha 0 shows top bit at once
   always @(negedge sel_n) begin
      out = tx_byte;
      if (!cpha) begin
         miso = out[7];
         out = out << 1;
      end
   end

   // A released line must not keep the last bit, so show its inverse
   always @(posedge sel_n) miso = ~miso;

   // Clock watched, never driven
   always @(sclk) begin
      if (!sel_n) begin
         if ((sclk != cpol) == cpha) begin
            miso = out[7];
            out = out << 1;
         end else begin
            rx_byte = {rx_byte[6:0], mosi};
         end
      end
   end
endmodule : spi_slave_model

// [sim/spi_board_select_fabric_tb.sv]
// Self-checking bench for the SPI master and select fabric
`include "spi_fabric_defines.svh"
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin n_fail++; \
   $display("ERROR %s expected %0h seen %0h", what, exp, got); end end

module spi_board_select_fabric_tb;
   import spi_fabric_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'h0, rst_n, cmd_valid = 1'h0, rx_ready = 1'h1, cmd_ready, rx_valid, busy;
   cmd_type cmd = '0;
   rx_type rx;
   radio_status_type radio_status;
   logic radio_reset_req = 1'h0, radio_power_on = 1'h0, sclk, mosi, miso, radio_reset_n, radio_regulator_enable;
   logic power_ctrl_select_n, radio_select_n, board_select_near_n, board_select_far_n;
   logic sub_addr_bit0, sub_addr_bit1, sub_addr_bit2;
   logic rx_threshold_flag = 1'h0, rx_bytes_present = 1'h0, frame_start = 1'h0, channel_clear = 1'h0;
   logic [3:0] sels, sel_seen, prev_sel = 4'hF;
   logic [2:0] addr_seen;
   logic sclk_seen, s_cpol = 1'h0, s_cpha = 1'h0;
   logic [7:0] s_tx = 8'h00, s_rx;
   int n_fail = 0, compares = 0;

   always #20 ref_clk = ~ref_clk;
   assign sels = {board_select_far_n, board_select_near_n, radio_select_n, power_ctrl_select_n};

   spi_board_select_fabric #(.HALF_CYCLES(4), .FIFO_DEPTH(`CMD_FIFO_DEPTH)) uut (.ref_clk, .rst_n, .cmd_valid,
      .cmd_ready, .cmd, .rx_valid, .rx_ready, .rx, .busy, .radio_reset_req, .radio_power_on, .radio_status,
      .sclk, .mosi, .miso, .power_ctrl_select_n, .radio_select_n, .board_select_near_n, .board_select_far_n,
      .sub_addr_bit0, .sub_addr_bit1, .sub_addr_bit2, .radio_reset_n, .radio_regulator_enable,
      .rx_threshold_flag, .rx_bytes_present, .frame_start, .channel_clear);

   spi_slave_model partner (.sclk, .mosi, .sel_n(&sels), .cpol(s_cpol), .cpha(s_cpha), .tx_byte(s_tx),
      .miso, .rx_byte(s_rx));

   // Snapshot wires as a select goes low
   always @(negedge ref_clk) begin
      if (sels != 4'hF && prev_sel == 4'hF) begin
         sel_seen = sels;
         addr_seen = {sub_addr_bit2, sub_addr_bit1, sub_addr_bit0};
         sclk_seen = sclk;
      end
      prev_sel = sels;
   end

   // ****************************************************************
   // Bus tasks
   // ****************************************************************
   // Holds the command until a ready edge; caller drops valid
   task automatic push(input cmd_type c);
      logic r;
      cmd <= c;
      cmd_valid <= 1'h1;
      r = 1'h0;
      while (!r) begin
         @(negedge ref_clk);
         r = cmd_ready;
         @(posedge ref_clk);
      end
   endtask : push

   // Bounded wait for a byte
   task automatic get_rx(output rx_type got);
      int n;
      for (n = 0; n < 400; n++) begin
         @(negedge ref_clk);
         if (rx_valid === 1'h1) break;
      end
      `CHK("rx_valid", 1'h1, rx_valid)
      got = rx;
      @(posedge ref_clk);
   endtask : get_rx

   // One byte exchange checked from both the master and the slave side
   task automatic xfer(input logic [1:0] t, input logic [2:0] a, input logic [1:0] m, input logic [7:0] d,
      input logic [7:0] stx);
      rx_type got;
      s_tx = stx;
      s_cpol = m[1];
      s_cpha = m[0];
      sel_seen = 4'h0;
      push('{target: target_type'(t), sub_addr: a, mode: m, keep: 1'h0, data: d});
      cmd_valid <= 1'h0;
      get_rx(got);
      `CHK("rx data", stx, got.data)
      `CHK("rx target", t, got.target)
      `CHK("slave byte", d, s_rx)
      `CHK("select", 4'hF ^ (4'h1 << t), sel_seen)
      `CHK("idle clock", m[1], sclk_seen)
      if (t > 2'h1) `CHK("sub addr", a, addr_seen)
   endtask : xfer

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic test_reset();
      @(negedge ref_clk);
      `CHK("selects", 4'hF, sels)
      `CHK("radio reset", 1'h0, radio_reset_n)
      `CHK("cmd_ready", 1'h1, cmd_ready)
      `CHK("busy", 1'h0, busy)
      $display("test_reset done");
   endtask : test_reset

   // Both levels of every sideband line, status through the synchroniser
   task automatic test_radio();
      for (int i = 0; i < 2; i++) begin
         radio_reset_req <= ~i[0];
         radio_power_on <= ~i[0];
         {channel_clear, frame_start, rx_bytes_present, rx_threshold_flag} <= i[0] ? 4'h5 : 4'hA;
         repeat (3) @(posedge ref_clk);
         `CHK("radio reset", i[0], radio_reset_n)
         `CHK("regulator", ~i[0], radio_regulator_enable)
         `CHK("status", i[0] ? 4'h5 : 4'hA, radio_status)
      end
      $display("test_radio done");
   endtask : test_radio

   // Each clock mode on a different slave
   task automatic test_modes();
      for (int i = 0; i < 4; i++) xfer(i[1:0], 3'h2, i[1:0], 8'hA5 ^ i[7:0], 8'h3C + i[7:0]);
      $display("test_modes done");
   endtask : test_modes

   // Eight near board devices, then far board id memory
   task automatic test_sub_addr();
      for (int a = 0; a < 8; a++) xfer(2'h2, a[2:0], 2'h1, 8'h80 >> a, ~a[7:0]);
      xfer(2'h3, 3'h7, 2'h2, 8'h01, 8'hE7);
      $display("test_sub_addr done");
   endtask : test_sub_addr

   // Stall receive side, fill until refused, drain in order
   task automatic test_fifo();
      int n;
      logic r;
      rx_type got;
      rx_ready <= 1'h0;
      s_tx = 8'h5A;
      s_cpol = 1'h0;
      s_cpha = 1'h0;
      cmd_valid <= 1'h1;
      n = 0;
      r = 1'h1;
      while (r && n < 40) begin
         cmd <= '{target: target_type'(n[1:0]), sub_addr: 3'h1, mode: 2'h0, keep: 1'h0, data: n[7:0]};
         @(negedge ref_clk);
         r = cmd_ready;
         @(posedge ref_clk);
         if (r) n++;
      end
      `CHK("busy while full", 1'h1, busy)
      cmd_valid <= 1'h0;
      `CHK("accepted", `CMD_FIFO_DEPTH + 1, n)
      rx_ready <= 1'h1;
      for (int i = 0; i <= `CMD_FIFO_DEPTH; i++) begin
         get_rx(got);
         `CHK("drain target", i[1:0], got.target)
         `CHK("drain data", 8'h5A, got.data)
      end
      `CHK("last byte out", 8'h10, s_rx)
      repeat (8) @(posedge ref_clk);
      `CHK("busy after drain", 1'h0, busy)
      $display("test_fifo done");
   endtask : test_fifo

   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   // Traffic is about 2500 cycles; cut a hang far beyond
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      test_done();
   end

   initial begin
      // An edge into reset is needed to fire the asynchronous reset
      rst_n <= 1'h0;
      repeat (2) @(posedge ref_clk);
      test_reset();
      @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
      test_radio();
      test_modes();
      test_sub_addr();
      test_fifo();
      test_done();
   end
endmodule : spi_board_select_fabric_tb
